// ===== pced_top.v
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "pced_map.vh"
module pced_top #(
    parameter WIDTH = 8
) (
    input wire REF_CLK, // 40 MHz system clock
    input wire SRST, // Synchronous reset, active high
    input wire [WIDTH-1:0] PORTA_PIN, // Port A pins
    input wire [WIDTH-1:0] PORTB_PIN, // Port B pins
    input wire [WIDTH-1:0] PORTC_PIN, // Port C pins
    input wire PSEL, // APB select
    input wire PENABLE, // APB access phase
    input wire PWRITE, // APB direction
    input wire [11:0] PADDR, // APB byte address
    input wire [31:0] PWDATA, // APB write data
    output wire [31:0] PRDATA, // APB read data
    output wire PREADY, // APB ready
    output wire PSLVERR, // APB error
    output wire CHANGE_SUMMARY_FLAG, // OR of all pin flags
    output wire IRQ // Level interrupt
);
    reg [WIDTH-1:0] rise_en_ff [0:2];
    reg [WIDTH-1:0] fall_en_ff [0:2];
    reg master_en_ff;
    reg stat_ff;
    reg mask_ff;
    reg sum_prev_ff;
    reg [31:0] rdata_ff;
    reg [31:0] nxt_rdata;
    wire [WIDTH-1:0] pin_raw [0:2];
    wire [WIDTH-1:0] pin_lvl [0:2];
    wire [WIDTH-1:0] flags [0:2];
    wire [WIDTH-1:0] hits [0:2];
    wire [2:0] flag_we;
    wire acc;
    wire wr;
    wire sum;
    wire sum_rise;
    genvar g;

    ////////////////////////////////////////////////////////////////////////
    // Register decode helpers, used by both the write and read paths
    function [1:0] port_of;
        input [11:0] a;
        begin
            if (a < `PCED_OFF_PB_RISE) begin
                port_of = 2'h0;
            end else if (a < `PCED_OFF_PC_RISE) begin
                port_of = 2'h1;
            end else begin
                port_of = 2'h2;
            end
        end
    endfunction

    function [1:0] kind_of;
        input [11:0] a;
        reg [11:0] rel;
        begin
            // Widen the port index before scaling so the product cannot wrap
            rel = a - ({10'h000, port_of(a)} * 12'h00C);
            kind_of = rel[3:2];
        end
    endfunction

    function in_port_range;
        input [11:0] a;
        begin
            in_port_range = (a <= `PCED_OFF_PC_FLAG) && (a[1:0] == 2'h0);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB access: zero wait states, errors on unmapped or misaligned address
    assign acc = PSEL & PENABLE;
    assign wr = acc & PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = acc & ~(in_port_range(PADDR) || PADDR == `PCED_OFF_CTRL
        || PADDR == `PCED_OFF_IRQ_STAT || PADDR == `PCED_OFF_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // Per-port synchroniser, edge detector and flag register
    assign pin_raw[0] = PORTA_PIN;
    assign pin_raw[1] = PORTB_PIN;
    assign pin_raw[2] = PORTC_PIN;

    generate
        for (g = 0; g < 3; g = g + 1) begin : g_port
            assign flag_we[g] = wr && in_port_range(PADDR) && port_of(PADDR) == g
                && kind_of(PADDR) == 2'h2;

            pced_sync #(.WIDTH(WIDTH)) u_sync (
                .clk(REF_CLK),
                .srst(SRST),
                .din(pin_raw[g]),
                .dout(pin_lvl[g])
            );

            pced_port #(.WIDTH(WIDTH)) u_port (
                .clk(REF_CLK),
                .srst(SRST),
                .pin_lvl(pin_lvl[g]),
                .rise_en(rise_en_ff[g]),
                .fall_en(fall_en_ff[g]),
                .flag_we(flag_we[g]),
                .flag_wdata(PWDATA[WIDTH-1:0]),
                .flags(flags[g]),
                .edge_hit(hits[g])
            );

            // Enable registers for this port
            always @(posedge REF_CLK) begin
                if (SRST) begin
                    rise_en_ff[g] <= `PCED_RST_BYTE;
                    fall_en_ff[g] <= `PCED_RST_BYTE;
                end else if (wr && in_port_range(PADDR) && port_of(PADDR) == g) begin
                    if (kind_of(PADDR) == 2'h0) begin
                        rise_en_ff[g] <= PWDATA[WIDTH-1:0];
                    end
                    if (kind_of(PADDR) == 2'h1) begin
                        fall_en_ff[g] <= PWDATA[WIDTH-1:0];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Summary flag follows the live flags, so clearing all flags drops it
    assign sum = |{flags[0], flags[1], flags[2]};
    assign CHANGE_SUMMARY_FLAG = sum;
    assign sum_rise = sum & ~sum_prev_ff;

    ////////////////////////////////////////////////////////////////////////
    // Master enable, sticky status (write one to clear), mask
    always @(posedge REF_CLK) begin
        if (SRST) begin
            master_en_ff <= `PCED_RST_BIT;
            stat_ff <= `PCED_RST_BIT;
            mask_ff <= `PCED_RST_BIT;
            sum_prev_ff <= `PCED_RST_BIT;
        end else begin
            sum_prev_ff <= sum;
            if (wr && PADDR == `PCED_OFF_CTRL) begin
                master_en_ff <= PWDATA[`PCED_CTRL_MEN_BIT];
            end
            if (wr && PADDR == `PCED_OFF_IRQ_MASK) begin
                mask_ff <= PWDATA[`PCED_STAT_SUM_BIT];
            end
            // A new summary event beats a simultaneous clear
            if (sum_rise) begin
                stat_ff <= 1'b1;
            end else if (wr && PADDR == `PCED_OFF_IRQ_STAT && PWDATA[`PCED_STAT_SUM_BIT]) begin
                stat_ff <= 1'b0;
            end
        end
    end

    // Master enable gates only the request; detection keeps running
    assign IRQ = master_en_ff & mask_ff & stat_ff;

    ////////////////////////////////////////////////////////////////////////
    // Read mux, registered so PRDATA comes from flip-flops
    always @* begin
        nxt_rdata = 32'h00000000;
        if (in_port_range(PADDR)) begin
            case (kind_of(PADDR))
                2'h0: nxt_rdata[WIDTH-1:0] = rise_en_ff[port_of(PADDR)];
                2'h1: nxt_rdata[WIDTH-1:0] = fall_en_ff[port_of(PADDR)];
                2'h2: nxt_rdata[WIDTH-1:0] = flags[port_of(PADDR)];
                default: nxt_rdata = 32'h00000000;
            endcase
        end else if (PADDR == `PCED_OFF_CTRL) begin
            nxt_rdata[`PCED_CTRL_MEN_BIT] = master_en_ff;
        end else if (PADDR == `PCED_OFF_IRQ_STAT) begin
            nxt_rdata[`PCED_STAT_SUM_BIT] = stat_ff;
        end else if (PADDR == `PCED_OFF_IRQ_MASK) begin
            nxt_rdata[`PCED_STAT_SUM_BIT] = mask_ff;
        end
    end

    // Captured in setup phase so data is stable through the access cycle
    always @(posedge REF_CLK) begin
        if (SRST) begin
            rdata_ff <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            rdata_ff <= nxt_rdata;
        end
    end
    assign PRDATA = rdata_ff;
endmodule // pced_top

// ===== pced_map.vh
`ifndef PCED_MAP_VH
`define PCED_MAP_VH
// Register byte offsets on the APB slave
`define PCED_OFF_PA_RISE 12'h000
`define PCED_OFF_PA_FALL 12'h004
`define PCED_OFF_PA_FLAG 12'h008
`define PCED_OFF_PB_RISE 12'h00C
`define PCED_OFF_PB_FALL 12'h010
`define PCED_OFF_PB_FLAG 12'h014
`define PCED_OFF_PC_RISE 12'h018
`define PCED_OFF_PC_FALL 12'h01C
`define PCED_OFF_PC_FLAG 12'h020
`define PCED_OFF_CTRL 12'h024
`define PCED_OFF_IRQ_STAT 12'h028
`define PCED_OFF_IRQ_MASK 12'h02C
// Field positions
`define PCED_CTRL_MEN_BIT 0
`define PCED_STAT_SUM_BIT 0
// Reset values
`define PCED_RST_BYTE 8'h00
`define PCED_RST_BIT 1'b0
`endif

// ===== pced_sync.v
`timescale 1ns/1ps
// Three-stage pin synchroniser with agreement filter
module pced_sync #(
    parameter WIDTH = 8
) (
    input wire clk, // System clock
    input wire srst, // Synchronous reset
    input wire [WIDTH-1:0] din, // Asynchronous pins
    output wire [WIDTH-1:0] dout // Filtered level
);
    reg [WIDTH-1:0] s1_ff;
    reg [WIDTH-1:0] s2_ff;
    reg [WIDTH-1:0] s3_ff;
    reg [WIDTH-1:0] lvl_ff;
    ////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second; level moves when stages 2 and 3 agree
    always @(posedge clk) begin
        if (srst) begin
            s1_ff <= {WIDTH{1'b0}};
            s2_ff <= {WIDTH{1'b0}};
            s3_ff <= {WIDTH{1'b0}};
            lvl_ff <= {WIDTH{1'b0}};
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
        end
    end
    assign dout = lvl_ff;
endmodule // pced_sync

// ===== pced_port.v
`timescale 1ns/1ps
`include "pced_map.vh"
// Edge detector and flag register for one 8-bit port
module pced_port #(
    parameter WIDTH = 8
) (
    input wire clk, // System clock
    input wire srst, // Synchronous reset
    input wire [WIDTH-1:0] pin_lvl, // Synchronised pin levels
    input wire [WIDTH-1:0] rise_en, // Rising enables
    input wire [WIDTH-1:0] fall_en, // Falling enables
    input wire flag_we, // Software write to flags
    input wire [WIDTH-1:0] flag_wdata, // Written flag value
    output wire [WIDTH-1:0] flags, // Flag state
    output wire [WIDTH-1:0] edge_hit // Qualified edge this cycle
);
    reg [WIDTH-1:0] prev_ff;
    reg [WIDTH-1:0] flag_ff;
    reg [WIDTH-1:0] nxt_flag;
    wire [WIDTH-1:0] rise_hit;
    wire [WIDTH-1:0] fall_hit;
    ////////////////////////////////////////////////////////////////////////
    // Edge = current sample differs from previous cycle's sample
    assign rise_hit = pin_lvl & ~prev_ff & rise_en;
    assign fall_hit = ~pin_lvl & prev_ff & fall_en;
    assign edge_hit = rise_hit | fall_hit;
    // Hardware set wins over any software write in the same cycle
    always @* begin
        nxt_flag = flag_ff;
        if (flag_we) begin
            nxt_flag = flag_wdata;
        end
        nxt_flag = nxt_flag | edge_hit;
    end
    // Sample history seeds from reset level, so no edge fakes itself at release
    always @(posedge clk) begin
        if (srst) begin
            prev_ff <= {WIDTH{1'b0}};
            flag_ff <= {WIDTH{1'b0}};
        end else begin
            prev_ff <= pin_lvl;
            flag_ff <= nxt_flag;
        end
    end
    assign flags = flag_ff;
endmodule // pced_port

// ===== pced_pins.sv
`timescale 1ns/1ps
// Far side: external pins driven as clean levels, changed only after a clock edge
module pced_pins (
    input wire clk, // Bench clock
    input wire [23:0] want, // Requested levels, port A high byte
    output reg [7:0] pa = 8'h00, // Port A pins
    output reg [7:0] pb = 8'h00, // Port B pins
    output reg [7:0] pc = 8'h00 // Port C pins
);
    // Pins are always driven, so the last level stands; no release state exists
    always @(posedge clk) begin
        {pa, pb, pc} <= want;
    end
endmodule // pced_pins

// ===== pced_properties.sv
`timescale 1ns/1ps
module pced_chk #(
    parameter WIDTH = 8
) (
    input wire REF_CLK, // Clock
    input wire SRST, // Reset
    input wire [WIDTH-1:0] PORTA_PIN, // Port A
    input wire [WIDTH-1:0] PORTB_PIN, // Port B
    input wire [WIDTH-1:0] PORTC_PIN, // Port C
    input wire PSEL, // APB
    input wire PENABLE, // APB
    input wire PWRITE, // APB
    input wire [11:0] PADDR, // APB
    input wire [31:0] PWDATA, // APB
    input wire [31:0] PRDATA, // APB
    input wire PREADY, // APB
    input wire PSLVERR, // APB
    input wire CHANGE_SUMMARY_FLAG, // Summary
    input wire IRQ // Interrupt
);
    reg [3:0] calm_ff = 4'h0;
    reg [3*WIDTH-1:0] last_ff = {3*WIDTH{1'b0}};
    wire wr_acc = PSEL && PENABLE && PWRITE;
    wire bad_adr = (PADDR > 12'h02C) || (PADDR[1:0] != 2'b00);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin quiet counter; saturates so long idle spans cannot wrap back below 8 and switch off the quiet-pin check
    always @(posedge REF_CLK) begin
        last_ff <= {PORTA_PIN, PORTB_PIN, PORTC_PIN};
        if (SRST || last_ff != {PORTA_PIN, PORTB_PIN, PORTC_PIN}) calm_ff <= 4'h0;
        else if (calm_ff != 4'hF) calm_ff <= calm_ff + 4'h1;
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    ////////////////////////////////////////////////////////////////////////////////
    a_reset_summary: assert property (disable iff (1'b0) SRST |=> !CHANGE_SUMMARY_FLAG)
        else $error("summary flag set after reset");
    a_reset_irq: assert property (disable iff (1'b0) SRST |=> !IRQ)
        else $error("interrupt set after reset");
    a_no_spurious: assert property (calm_ff >= 4'h8 && !wr_acc |=> !$rose(CHANGE_SUMMARY_FLAG))
        else $error("flag rose with quiet pins");
    a_flag_sticky: assert property (CHANGE_SUMMARY_FLAG && !wr_acc |=> CHANGE_SUMMARY_FLAG)
        else $error("summary dropped without a write");
    a_irq_sticky: assert property (IRQ && !wr_acc |=> IRQ)
        else $error("interrupt dropped without a write");
    a_irq_cause: assert property ($rose(IRQ) |-> $past(wr_acc) || $past(CHANGE_SUMMARY_FLAG))
        else $error("interrupt rose without flag or write");
    a_err_unmapped: assert property (PSEL && PENABLE && bad_adr |-> PSLVERR)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (PSEL && PENABLE && !bad_adr |-> !PSLVERR)
        else $error("error on mapped access");
    a_rdata_width: assert property (PSEL && PENABLE && !PWRITE |-> PRDATA[31:8] == 24'h0)
        else $error("read data above bit 7");
    a_ready_zero_wait: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("access phase stalled");
    c_flag_rise: cover property ($rose(CHANGE_SUMMARY_FLAG));
    c_irq_rise: cover property ($rose(IRQ));
    c_err_seen: cover property (PSEL && PENABLE && PSLVERR);
endmodule // pced_chk
bind pced_top pced_chk #(.WIDTH(WIDTH)) u_chk (.REF_CLK(REF_CLK), .SRST(SRST),
    .PORTA_PIN(PORTA_PIN), .PORTB_PIN(PORTB_PIN), .PORTC_PIN(PORTC_PIN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CHANGE_SUMMARY_FLAG(CHANGE_SUMMARY_FLAG), .IRQ(IRQ));

// ===== pced_top_tb.sv
`timescale 1ns/1ps
module pced_top_tb;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [23:0] want = 24'h0;
    wire [7:0] pa, pb, pc;
    wire [31:0] prdata;
    wire pready, pslverr, sum, irq;
    integer err_count = 0;
    integer total_checks = 0;
    integer i;
    reg [31:0] q;
    reg e;
    always #12.5 clk = ~clk;
    pced_pins i_pins (.clk(clk), .want(want), .pa(pa), .pb(pb), .pc(pc));
    pced_top #(.WIDTH(8)) i_dut (.REF_CLK(clk), .SRST(srst), .PORTA_PIN(pa), .PORTB_PIN(pb),
        .PORTC_PIN(pc), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CHANGE_SUMMARY_FLAG(sum), .IRQ(irq));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task chk(input [31:0] seen, input [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen at an edge
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input [11:0] a, input [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, {24'h0, exp});
    endtask
    task wr(input [11:0] a, input [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    // Pin change, then enough cycles for synchroniser and flag to settle
    task pins(input [23:0] v);
        @(posedge clk);
        want <= v;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog; the whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk);
        err_count = err_count + 1;
        report_and_stop;
    end
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 12; i = i + 1) rd(12'(4 * i), 8'h00);
        for (i = 0; i < 9; i = i + 1) wr(12'(4 * i), 8'h5A ^ 8'(i));
        for (i = 0; i < 9; i = i + 1) rd(12'(4 * i), 8'h5A ^ 8'(i));
        @(negedge clk);
        chk(sum, 1'b1);
        for (i = 0; i < 9; i = i + 1) wr(12'(4 * i), 8'h00);
        rd(12'h014, 8'h00);
        @(negedge clk);
        chk(sum, 1'b0);
        apb(1'b0, 12'h030, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, 12'h006, 32'hFF);
        chk(e, 1'b1);
        wr(12'h000, 8'h01);
        wr(12'h004, 8'h02);
        wr(12'h00C, 8'h80);
        wr(12'h010, 8'h80);
        wr(12'h018, 8'h08);
        pins(24'h030000);
        rd(12'h008, 8'h01);
        chk(sum, 1'b1);
        pins(24'h000000);
        rd(12'h008, 8'h03);
        wr(12'h008, 8'h00);
        rd(12'h008, 8'h00);
        pins(24'h008000);
        rd(12'h014, 8'h80);
        wr(12'h014, 8'h00);
        pins(24'h000000);
        rd(12'h014, 8'h80);
        wr(12'h014, 8'h00);
        pins(24'h0000F8);
        rd(12'h020, 8'h08);
        rd(12'h008, 8'h00);
        wr(12'h02C, 8'h01);
        @(negedge clk);
        chk(irq, 1'b0);
        wr(12'h024, 8'h01);
        @(negedge clk);
        chk(irq, 1'b1);
        wr(12'h028, 8'h01);
        @(negedge clk);
        chk(irq, 1'b0);
        wr(12'h020, 8'h00);
        pins(24'h000000);
        chk(sum, 1'b0);
        pins(24'h000008);
        chk(irq, 1'b1);
        wr(12'h02C, 8'h00);
        @(negedge clk);
        chk(irq, 1'b0);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 12; i = i + 1) rd(12'(4 * i), 8'h00);
        report_and_stop;
    end
endmodule // pced_top_tb
